// *** rtl/pec_pkg.sv ***
// Shared constants and carrier types for the two-counter event monitor.
`default_nettype none
package pec_pkg;
    // Coprocessor register number and subaccess codes.
    localparam logic [4:0]  PEC_CP0_REG     = 5'h19;
    localparam logic [1:0]  PEC_SEL_CTRL    = 2'h0;
    localparam logic [1:0]  PEC_SEL_CNT0    = 2'h1;
    localparam logic [1:0]  PEC_SEL_CNT1    = 2'h2;
    // Control field positions for counter zero; counter one sits one stride higher.
    localparam int          PEC_CTE_BIT     = 31;
    localparam int          PEC_EV_LSB      = 5;
    localparam int          PEC_EV_W        = 5;
    localparam int          PEC_USER_BIT    = 4;
    localparam int          PEC_SUP_BIT     = 3;
    localparam int          PEC_KERN_BIT    = 2;
    localparam int          PEC_EXL_BIT     = 1;
    localparam int          PEC_CH_STRIDE   = 10;
    localparam logic [31:0] PEC_CTRL_MASK   = 32'h800ffbfe;
    localparam logic [31:0] PEC_CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] PEC_CNT_RESET   = 32'h0000_0000;
    // Event codes: sixteen real events, then no event and reserved codes.
    localparam int          PEC_NUM_EVENTS  = 16;
    localparam logic [4:0]  PEC_EV_NONE     = 5'h10;
    localparam logic [15:0] PEC_EV0_RSVD    = 16'h4001;
    localparam logic [15:0] PEC_EV1_RSVD    = 16'h0000;
    // Counter register layout.
    localparam int          PEC_WRAP_BIT    = 31;
    // Operating mode encoding of the core.
    localparam logic [1:0]  PEC_KSU_KERNEL  = 2'h0;
    localparam logic [1:0]  PEC_KSU_SUPER   = 2'h1;
    localparam logic [1:0]  PEC_KSU_USER    = 2'h2;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  reg_num;
        logic [1:0]  sel;
        logic [31:0] wdata;
    } pec_acc_t;

    typedef struct packed {
        logic       exception_level_flag;
        logic [1:0] ksu;
    } pec_mode_t;

    typedef struct packed {
        logic [1:0][15:0] hit;
    } pec_evt_t;

    typedef struct packed {
        logic [31:0]      ctrl;
        logic [1:0][31:0] cnt;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             exc_req;
        logic             err_pc_sel;
    } pec_state_t;
endpackage
`default_nettype wire

// *** rtl/pec_counters.sv ***
// Two-counter performance event monitor reached through coprocessor register 25.
//
// Notes on behaviour
// RULE_01 - One control and two counter registers, all at coprocessor register 25.
// RULE_02 - The two low instruction bits pick which of the three registers is reached.
// RULE_03 - Software reads and writes all three registers, reserved bits excepted.
// RULE_04 - Control bit 31 enables counting and the exception; it resets to zero.
// RULE_05 - Counter one event comes from control bits 19:15, codes 0 to 7.
// RULE_06 - Counter one codes 8 to 15 are events; 16 none; 17 to 31 reserved.
// RULE_07 - Counter zero event comes from control bits 9:5; code 0 reserved.
// RULE_08 - Counter zero codes 8 to 15 are events, 14 reserved; 16 none.
// RULE_09 - User mode counting needs bit 14 for counter one, bit 4 for zero.
// RULE_10 - Supervisor counting needs bit 13 for counter one, bit 3 for zero.
// RULE_11 - Kernel counting needs bit 12 for counter one, bit 2 for zero.
// RULE_12 - Counting at exception level needs bit 11 for counter one, bit 1 for zero.
// RULE_13 - Control bits 30:20, 10 and 0 are written as zero and read as zero.
// RULE_14 - Counter registers hold a 31-bit count and a wrap flag in bit 31.
// RULE_15 - A count wrap sets the wrap flag and, if enabled, requests the exception.
// RULE_16 - A counter advances once per selected event when enabled for the mode.
// RULE_17 - The counter exception resumes through the error resume address.
`default_nettype none
module pec_counters #(
    parameter int NUM_EVENTS = pec_pkg::PEC_NUM_EVENTS
) (
    // Clock, reset and freeze.
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Coprocessor move access.
    input  wire pec_pkg::pec_acc_t acc,
    output logic [31:0]            rdata,
    output logic                   rvalid,
    // Core state and event strobes.
    input  wire pec_pkg::pec_mode_t mode,
    input  wire pec_pkg::pec_evt_t  evt,
    // Exception request toward the core.
    output logic                   exc_req,
    output logic                   err_pc_sel
);
    // The event decode indexes sixteen lines per counter, so other widths are refused.
    if (NUM_EVENTS != 16) begin : g_bad_events
        $error("pec_counters serves exactly sixteen event lines");
    end

    pec_pkg::pec_state_t q;
    pec_pkg::pec_state_t n;

    logic             acc_hit;
    logic [1:0]       inc;
    logic [1:0]       wrap;
    logic [1:0]       wr;

    always_comb begin
        logic [1:0]       mode_en;
        logic [1:0]       ev_on;
        logic [1:0][4:0]  code;
        logic [1:0][31:0] sum;
        logic [15:0]      rsvd;
        int               base;
        mode_en = 2'b00;
        ev_on   = 2'b00;
        code    = '0;
        sum     = '0;
        rsvd    = 16'h0000;
        base    = 0;
        n        = q;
        n.rvalid = 1'b0;
        // Only accesses naming register 25 reach this block.
        acc_hit = acc.valid && (acc.reg_num == pec_pkg::PEC_CP0_REG); // RULE_01
        inc  = 2'b00;
        wrap = 2'b00;
        wr   = 2'b00;
        for (int i = 0; i < 2; i++) begin
            base = i * pec_pkg::PEC_CH_STRIDE;
            code[i] = q.ctrl[pec_pkg::PEC_EV_LSB + base +: pec_pkg::PEC_EV_W];
            rsvd = (i == 0) ? pec_pkg::PEC_EV0_RSVD : pec_pkg::PEC_EV1_RSVD;
            // No event, reserved codes and codes 17 to 31 never count.
            if (code[i] < pec_pkg::PEC_EV_NONE && !rsvd[code[i][3:0]]) begin
                ev_on[i] = evt.hit[i][code[i][3:0]]; // RULE_05 RULE_06 RULE_07 RULE_08
            end
            // Exception level overrides the mode field while it is set.
            if (mode.exception_level_flag) begin
                mode_en[i] = q.ctrl[pec_pkg::PEC_EXL_BIT + base]; // RULE_12
            end else begin
                case (mode.ksu)
                    pec_pkg::PEC_KSU_USER: begin
                        mode_en[i] = q.ctrl[pec_pkg::PEC_USER_BIT + base]; // RULE_09
                    end
                    pec_pkg::PEC_KSU_SUPER: begin
                        mode_en[i] = q.ctrl[pec_pkg::PEC_SUP_BIT + base]; // RULE_10
                    end
                    pec_pkg::PEC_KSU_KERNEL: begin
                        mode_en[i] = q.ctrl[pec_pkg::PEC_KERN_BIT + base]; // RULE_11
                    end
                    default: begin
                        mode_en[i] = 1'b0;
                    end
                endcase
            end
            inc[i] = q.ctrl[pec_pkg::PEC_CTE_BIT] && mode_en[i] && ev_on[i]; // RULE_04 RULE_16
            sum[i] = {1'b0, q.cnt[i][30:0]} + 32'h0000_0001;
            wrap[i] = inc[i] && sum[i][31];
            wr[i] = acc_hit && acc.write &&
                    (acc.sel == ((i == 0) ? pec_pkg::PEC_SEL_CNT0 : pec_pkg::PEC_SEL_CNT1));
            if (wr[i]) begin
                // A write replaces the count, but a wrap in the same cycle still flags.
                n.cnt[i] = acc.wdata; // RULE_14
                n.cnt[i][pec_pkg::PEC_WRAP_BIT] = acc.wdata[31] | wrap[i]; // RULE_15
            end else if (inc[i]) begin
                n.cnt[i][30:0] = sum[i][30:0]; // RULE_16
                if (wrap[i]) begin
                    n.cnt[i][pec_pkg::PEC_WRAP_BIT] = 1'b1; // RULE_15
                end
            end
        end
        if (acc_hit && acc.write && acc.sel == pec_pkg::PEC_SEL_CTRL) begin
            n.ctrl = acc.wdata & pec_pkg::PEC_CTRL_MASK; // RULE_03 RULE_13
        end
        if (acc_hit && !acc.write) begin
            n.rvalid = 1'b1;
            case (acc.sel) // RULE_02 RULE_03
                pec_pkg::PEC_SEL_CTRL: begin
                    n.rdata = q.ctrl;
                end
                pec_pkg::PEC_SEL_CNT0: begin
                    n.rdata = q.cnt[0];
                end
                pec_pkg::PEC_SEL_CNT1: begin
                    n.rdata = q.cnt[1];
                end
                default: begin
                    n.rdata = 32'h0000_0000;
                end
            endcase
        end
        // The request holds while enabled and any wrap flag is set.
        n.exc_req = n.ctrl[pec_pkg::PEC_CTE_BIT] &&
                    (n.cnt[0][pec_pkg::PEC_WRAP_BIT] || n.cnt[1][pec_pkg::PEC_WRAP_BIT]); // RULE_15
        n.err_pc_sel = n.exc_req; // RULE_17
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q.ctrl       <= pec_pkg::PEC_CTRL_RESET; // RULE_04
            q.cnt        <= {pec_pkg::PEC_CNT_RESET, pec_pkg::PEC_CNT_RESET};
            q.rdata      <= 32'h0000_0000;
            q.rvalid     <= 1'b0;
            q.exc_req    <= 1'b0;
            q.err_pc_sel <= 1'b0;
        end else if (ce) begin
            q <= n;
        end
    end

    assign rdata      = q.rdata;
    assign rvalid     = q.rvalid;
    assign exc_req    = q.exc_req;
    assign err_pc_sel = q.err_pc_sel;

    // Checks on the register file and counting.
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
        (q.ctrl & ~pec_pkg::PEC_CTRL_MASK) == 32'h0000_0000) // RULE_13
        else $error("reserved control bits are not zero");

    chk_reset_disable: assert property (@(posedge clk)
        !rstn |=> !q.ctrl[31] && !q.exc_req) // RULE_04
        else $error("global enable or request set after reset");

    chk_disabled_hold: assert property (@(posedge clk) disable iff (!rstn)
        ce && !q.ctrl[31] && !(acc_hit && acc.write) |=> $stable(q.cnt)) // RULE_04
        else $error("counter moved while globally disabled");

    chk_count_step: assert property (@(posedge clk) disable iff (!rstn)
        ce && inc[0] && !wr[0] |=> q.cnt[0][30:0] == $past(q.cnt[0][30:0]) + 31'h1) // RULE_16
        else $error("counter zero did not step by one");

    chk_user_gate: assert property (@(posedge clk) disable iff (!rstn)
        ce && !mode.exception_level_flag && mode.ksu == pec_pkg::PEC_KSU_USER && !q.ctrl[14] && !wr[1]
        |=> $stable(q.cnt[1])) // RULE_09
        else $error("counter one counted in user mode while disabled");

    chk_exl_gate: assert property (@(posedge clk) disable iff (!rstn)
        ce && mode.exception_level_flag && !q.ctrl[1] && !wr[0] |=> $stable(q.cnt[0])) // RULE_12
        else $error("counter zero counted at exception level while disabled");

    chk_wrap_flag: assert property (@(posedge clk) disable iff (!rstn)
        ce && inc[1] && q.cnt[1][30:0] == 31'h7fffffff
        |=> q.cnt[1][31] && q.cnt[1][30:0] == 31'h0) // RULE_15
        else $error("wrap did not set the flag");

    chk_exc_follow: assert property (@(posedge clk) disable iff (!rstn)
        q.ctrl[31] && (q.cnt[0][31] || q.cnt[1][31]) |-> q.exc_req && q.err_pc_sel) // RULE_15 RULE_17
        else $error("exception request missing while a flag is set");

    chk_read_ctrl: assert property (@(posedge clk) disable iff (!rstn)
        ce && acc_hit && !acc.write && acc.sel == pec_pkg::PEC_SEL_CTRL
        |=> rvalid && rdata == $past(q.ctrl)) // RULE_02 RULE_03
        else $error("control read returned wrong data");

    chk_write_cnt: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr[1] && !wrap[1] |=> q.cnt[1] == $past(acc.wdata)) // RULE_14
        else $error("counter one write not stored");

    chk_foreign_reg: assert property (@(posedge clk) disable iff (!rstn)
        ce && acc.valid && acc.reg_num != pec_pkg::PEC_CP0_REG |=> !rvalid) // RULE_01
        else $error("access to another register answered");

    chk_read_cnt0: assert property (@(posedge clk) disable iff (!rstn) // RULE_02 RULE_03
        ce && acc_hit && !acc.write && acc.sel == pec_pkg::PEC_SEL_CNT0
        |=> rvalid && rdata == $past(q.cnt[0]))
        else $error("counter zero read returned wrong data");

    chk_read_cnt1: assert property (@(posedge clk) disable iff (!rstn) // RULE_02 RULE_03
        ce && acc_hit && !acc.write && acc.sel == pec_pkg::PEC_SEL_CNT1
        |=> rvalid && rdata == $past(q.cnt[1]))
        else $error("counter one read returned wrong data");

    chk_read_unmapped: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        ce && acc_hit && !acc.write && acc.sel == 2'h3 |=> rvalid && rdata == 32'h0000_0000)
        else $error("unmapped subaccess read not zero");

    chk_no_answer: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        ce && !(acc_hit && !acc.write) |=> !rvalid)
        else $error("read answer without a read");

    chk_write_ctrl: assert property (@(posedge clk) disable iff (!rstn) // RULE_03 RULE_13
        ce && acc_hit && acc.write && acc.sel == pec_pkg::PEC_SEL_CTRL
        |=> q.ctrl == ($past(acc.wdata) & pec_pkg::PEC_CTRL_MASK))
        else $error("control write not stored");

    chk_write_cnt0: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        ce && wr[0] && !wrap[0] |=> q.cnt[0] == $past(acc.wdata))
        else $error("counter zero write not stored");

    chk_clash_flag: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
        ce && wr[0] && wrap[0] |=> q.cnt[0][31])
        else $error("wrap lost under a counter write");

    chk_count_step1: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        ce && inc[1] && !wr[1] |=> q.cnt[1][30:0] == $past(q.cnt[1][30:0]) + 31'h1)
        else $error("counter one did not step by one");

    chk_wrap_flag0: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
        ce && inc[0] && !wr[0] && q.cnt[0][30:0] == 31'h7fffffff
        |=> q.cnt[0][31] && q.cnt[0][30:0] == 31'h0)
        else $error("counter zero wrap did not set the flag");

    chk_flag_keep0: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        ce && !wr[0] && q.cnt[0][31] |=> q.cnt[0][31])
        else $error("counter zero flag cleared without a write");

    chk_flag_keep1: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        ce && !wr[1] && q.cnt[1][31] |=> q.cnt[1][31])
        else $error("counter one flag cleared without a write");

    chk_user_gate0: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        ce && !mode.exception_level_flag && mode.ksu == pec_pkg::PEC_KSU_USER && !q.ctrl[4] && !wr[0]
        |=> $stable(q.cnt[0]))
        else $error("counter zero counted in user mode while disabled");

    chk_sup_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        ce && !mode.exception_level_flag && mode.ksu == pec_pkg::PEC_KSU_SUPER && !q.ctrl[3] && !wr[0]
        |=> $stable(q.cnt[0]))
        else $error("counter zero counted in supervisor mode while disabled");

    chk_kern_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        ce && !mode.exception_level_flag && mode.ksu == pec_pkg::PEC_KSU_KERNEL && !q.ctrl[12] && !wr[1]
        |=> $stable(q.cnt[1]))
        else $error("counter one counted in kernel mode while disabled");

    chk_exl_gate1: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
        ce && mode.exception_level_flag && !q.ctrl[11] && !wr[1] |=> $stable(q.cnt[1]))
        else $error("counter one counted at exception level while disabled");

    chk_none_code0: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        ce && q.ctrl[9:5] >= 5'h10 && !wr[0] |=> $stable(q.cnt[0]))
        else $error("counter zero counted on no event or a reserved code");

    chk_rsvd_code0: assert property (@(posedge clk) disable iff (!rstn) // RULE_07 RULE_08
        ce && (q.ctrl[9:5] == 5'h0 || q.ctrl[9:5] == 5'he) && !wr[0] |=> $stable(q.cnt[0]))
        else $error("counter zero counted on a reserved code");

    chk_none_code1: assert property (@(posedge clk) disable iff (!rstn) // RULE_05 RULE_06
        ce && q.ctrl[19:15] >= 5'h10 && !wr[1] |=> $stable(q.cnt[1]))
        else $error("counter one counted on no event or a reserved code");

    chk_event_counts: assert property (@(posedge clk) disable iff (!rstn) // RULE_05 RULE_16
        ce && q.ctrl[31] && !mode.exception_level_flag && mode.ksu == pec_pkg::PEC_KSU_KERNEL && q.ctrl[12]
        && q.ctrl[19:15] < 5'h10 && evt.hit[1][q.ctrl[18:15]] && !wr[1]
        |=> q.cnt[1][30:0] == $past(q.cnt[1][30:0]) + 31'h1)
        else $error("counter one missed a selected event");

    chk_exc_off: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        !q.ctrl[31] |-> !q.exc_req)
        else $error("exception request while globally disabled");

    chk_err_sel: assert property (@(posedge clk) disable iff (!rstn) // RULE_17
        err_pc_sel == exc_req)
        else $error("error resume selection differs from the request");

    chk_freeze_hold: assert property (@(posedge clk) disable iff (!rstn)
        !ce |=> $stable(q))
        else $error("state moved while the clock enable was low");

    cov_wrap:  cover property (@(posedge clk) disable iff (!rstn) wrap[0] || wrap[1]);
    cov_exc:   cover property (@(posedge clk) disable iff (!rstn) $rose(exc_req));
    cov_both:  cover property (@(posedge clk) disable iff (!rstn) inc == 2'b11);
    cov_clash: cover property (@(posedge clk) disable iff (!rstn) ce && wr[0] && inc[0]);
    cov_freeze: cover property (@(posedge clk) disable iff (!rstn) !ce && inc != 2'b00);
endmodule
`default_nettype wire

// *** dv/pec_core_model.sv ***
// Core-side model that raises event strobes for the counter monitor.
`default_nettype none
module pec_core_model (
    // Clock.
    input  wire logic         clk,
    // Event choice from the bench.
    input  wire logic         fire,
    input  wire logic [4:0]   code0,
    input  wire logic [4:0]   code1,
    // Event strobes toward the monitor.
    output var pec_pkg::pec_evt_t evt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] noise = 32'h0;
    logic [31:0] pick;
    // Unselected lines toggle at random, so only the chosen code may count.
    always @(posedge clk) begin
        noise <= $urandom;
    end
    always_comb begin
        pick = 32'h0;
        if (code0 < 5'h10) pick[code0] = 1'b1;
        if (code1 < 5'h10) pick[16 + code1] = 1'b1;
        evt.hit = (noise & ~pick) | (fire ? pick : 32'h0);
    end
endmodule
`default_nettype wire

// *** dv/pec_counters_tb_top.sv ***
// Self-checking bench for the two-counter event monitor.
`default_nettype none
module pec_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               fire = 1'b0;
    logic               ce = 1'b1;
    logic [4:0]         code0 = 5'h0;
    logic [4:0]         code1 = 5'h0;
    pec_pkg::pec_acc_t  acc = '0;
    pec_pkg::pec_mode_t mode = '0;
    pec_pkg::pec_evt_t  evt;
    logic [31:0]        rdata;
    logic               rvalid;
    logic               exc_req;
    logic               err_pc_sel;
    int                 failures = 0;
    int                 compares = 0;
    int                 cycles = 0;
    always #2 clk = ~clk;
    pec_counters i_pec_counters (.clk(clk), .rstn(rstn), .ce(ce), .acc(acc),
        .rdata(rdata), .rvalid(rvalid), .mode(mode), .evt(evt), .exc_req(exc_req),
        .err_pc_sel(err_pc_sel));
    pec_core_model i_pec_core_model (.clk(clk), .fire(fire), .code0(code0), .code1(code1),
        .evt(evt));
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cp_acc(input logic wr, input logic [4:0] rn, input logic [1:0] sel,
                          input logic [31:0] d);
        @(posedge clk);
        acc <= '{1'b1, wr, rn, sel, d};
        @(posedge clk);
        acc.valid <= 1'b0;
        #1;
    endtask
    task automatic cp_rd(input logic [1:0] sel, input logic [31:0] exp);
        cp_acc(1'b0, 5'h19, sel, 32'h0);
        check({31'h0, rvalid}, 32'h1);
        check(rdata, exp);
    endtask
    // Whether a counter should advance under a control word and core mode.
    function automatic logic counts(logic [31:0] c, int ch, pec_pkg::pec_mode_t m);
        int b;
        logic [4:0] code;
        b = ch * 10;
        code = c[b + 5 +: 5];
        if (!c[31] || code > 5'hf) return 1'b0;
        if (ch == 0 && (code == 5'h0 || code == 5'he)) return 1'b0;
        if (m.exception_level_flag) return c[b + 1];
        if (m.ksu == 2'h3) return 1'b0;
        return c[b + 2 + int'(m.ksu)];
    endfunction
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        logic [31:0] ctl;
        logic [31:0] w;
        int n;
        w = $urandom(32'h004e6e08);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        cp_rd(2'h0, 32'h0);
        cp_rd(2'h1, 32'h0);
        cp_rd(2'h2, 32'h0);
        cp_acc(1'b1, 5'h19, 2'h0, 32'hffffffff);
        cp_rd(2'h0, 32'h800ffbfe);
        for (int s = 1; s < 3; s++) begin
            w = $urandom;
            cp_acc(1'b1, 5'h19, s[1:0], w);
            cp_acc(1'b1, 5'h18, s[1:0], ~w);
            cp_rd(s[1:0], w);
        end
        cp_rd(2'h3, 32'h0);
        // Event codes 0 to 20 on both counters, with random mode and enables.
        for (int c = 0; c < 21; c++) begin
            ctl = ($urandom & 32'h0000781e) | (32'(c) << 5) | (32'(20 - c) << 15);
            ctl[31] = (c % 5 != 4);
            mode <= pec_pkg::pec_mode_t'(3'($urandom_range(7)));
            code0 <= ctl[9:5];
            code1 <= ctl[19:15];
            cp_acc(1'b1, 5'h19, 2'h0, ctl);
            cp_acc(1'b1, 5'h19, 2'h1, 32'h0);
            cp_acc(1'b1, 5'h19, 2'h2, 32'h0);
            n = $urandom_range(8, 1);
            fire <= 1'b1;
            repeat (n) @(posedge clk);
            fire <= 1'b0;
            cp_rd(2'h1, counts(ctl, 0, mode) ? 32'(n) : 32'h0);
            cp_rd(2'h2, counts(ctl, 1, mode) ? 32'(n) : 32'h0);
        end
        mode <= '0;
        code0 <= 5'h1;
        code1 <= 5'h0;
        cp_acc(1'b1, 5'h19, 2'h0, 32'h80000024);
        cp_acc(1'b1, 5'h19, 2'h1, 32'h7fffffff);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
        check({30'h0, exc_req, err_pc_sel}, 32'h3);
        cp_rd(2'h1, 32'h80000000);
        cp_acc(1'b1, 5'h19, 2'h1, 32'h0);
        @(posedge clk);
        #1;
        check({31'h0, exc_req}, 32'h0);
        cp_acc(1'b1, 5'h19, 2'h0, 32'h0);
        cp_acc(1'b1, 5'h19, 2'h1, 32'h80000000);
        @(posedge clk);
        #1;
        check({31'h0, exc_req}, 32'h0);
        // Freeze: events while the clock enable is low must not count.
        cp_acc(1'b1, 5'h19, 2'h1, 32'h5);
        cp_acc(1'b1, 5'h19, 2'h0, 32'h80000024);
        ce <= 1'b0;
        fire <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        fire <= 1'b0;
        cp_rd(2'h1, 32'h5);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        cp_rd(2'h1, 32'h6);
        // Reset in mid-run clears the control word and the counters.
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        cp_rd(2'h0, 32'h0);
        cp_rd(2'h1, 32'h0);
        check({31'h0, exc_req}, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
